// ---- ntsr_pkg.sv ----
// package: constants for the nand tree test and soft reset block
`default_nettype none
package ntsr_pkg;
   // strap and chain
   localparam int           MODE_W          = 5;
   localparam logic [4:0]   MODE_NAND_TREE  = 5'h04;
   localparam int           CHAIN_LEN       = 17;
   // register bus
   localparam int           ADDR_W          = 5;
   localparam int           DATA_W          = 16;
   localparam logic [4:0]   ADDR_BASIC_CTRL = 5'h00;
   localparam logic [4:0]   ADDR_CTRL       = 5'h01;
   localparam logic [4:0]   ADDR_IO_TUNE    = 5'h02;
   localparam logic [4:0]   ADDR_RX_DLL     = 5'h03;
   localparam logic [4:0]   ADDR_TX_DLL     = 5'h04;
   localparam logic [4:0]   ADDR_TRIM       = 5'h05;
   localparam logic [4:0]   ADDR_OVR_LO     = 5'h06;
   localparam logic [4:0]   ADDR_OVR_HI     = 5'h07;
   localparam logic [4:0]   ADDR_STRAP_CFG  = 5'h08;
   localparam logic [4:0]   ADDR_DBG_CTRL2  = 5'h09;
   localparam logic [4:0]   ADDR_STATUS     = 5'h0A;
   localparam logic [4:0]   ADDR_ANA_BASE   = 5'h10;
   localparam int           ANA_NUM         = 7;
   // field positions
   localparam int           BIT_SOFT_RST    = 15;
   localparam int           BIT_LOGIC_RST   = 0;
   localparam int           BIT_AFE_RST     = 0;
   // reset values
   localparam logic [15:0]  RST_BASIC_CTRL  = 16'h1140;
   localparam logic [15:0]  RST_CTRL        = 16'h0000;
   localparam logic [15:0]  RST_IO_TUNE     = 16'h0000;
   localparam logic [15:0]  RST_RX_DLL      = 16'h0000;
   localparam logic [15:0]  RST_TX_DLL      = 16'h0000;
   localparam logic [15:0]  RST_TRIM        = 16'h0000;
   localparam logic [15:0]  RST_OVR        = 16'h0000;
   localparam logic [15:0]  RST_ANA         = 16'h0000;
   // timing: soft reset sequence length
   localparam int           RST_TIME_NS     = 1000;
   localparam int           CLK_PERIOD_NS   = 100;
   localparam logic [7:0]   RST_CYCLES      =
      8'((RST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   typedef enum logic [1:0]
   {
      NTSR_IDLE  = 2'b00,
      NTSR_RESET = 2'b01,
      NTSR_DONE  = 2'b11
   } ntsr_state_e;
endpackage
`default_nettype wire

// ---- ntsr_nand_chain.sv ----
// module: nand chain evaluated over ordered pins, registered result
`default_nettype none
module ntsr_nand_chain
   import ntsr_pkg::*;
(
   input  wire logic                  clk,
   input  wire logic                  rst_n,
   input  wire logic                  clkEn,
   input  wire logic [CHAIN_LEN-1:0]  chainIn,
   output logic                       treeOut
);
   logic [CHAIN_LEN:0] stage;
   logic               treeOut_next;

   assign stage[0] = 1'b1;
   genvar i;
   generate
      for (i = 0; i < CHAIN_LEN; i++)
      begin : g_stage
         assign stage[i+1] = ~(chainIn[i] & stage[i]);
      end
   endgenerate
   assign treeOut_next = ~stage[CHAIN_LEN];

   always_ff @(posedge clk)
   begin
      if (!rst_n)
         treeOut <= 1'b0;
      else if (clkEn)
         treeOut <= treeOut_next;
   end

   // input 0 toggled, all later inputs high: an even index follows
   // rst_n in the antecedent skips the release edge, where treeOut is 0
   a_chain_parity : assert property (
      @(posedge clk) disable iff (!rst_n)
      rst_n && clkEn && chainIn[CHAIN_LEN-1:1] == '1
      |=> !clkEn || treeOut == $past(chainIn[0]))
      else $error("even chain position does not follow its input");
endmodule
`default_nettype wire

// ---- ntsr_reset_seq.sv ----
// module: soft reset sequencer with self clearing completion
`default_nettype none
module ntsr_reset_seq
   import ntsr_pkg::*;
(
   input  wire logic  clk,
   input  wire logic  rst_n,
   input  wire logic  clkEn,
   input  wire logic  start,
   output logic       busy,
   output logic       done
);
   ntsr_state_e state_reg;
   ntsr_state_e state_next;
   logic [7:0]  cnt_reg;
   logic [7:0]  cnt_next;
   wire         cntLast = (cnt_reg == RST_CYCLES - 8'h01);

   always_comb
   begin
      state_next = state_reg;
      cnt_next   = cnt_reg;
      unique case (state_reg)
         NTSR_IDLE:
            if (start)
            begin
               state_next = NTSR_RESET;
               cnt_next   = 8'h00;
            end
         NTSR_RESET:
            if (cntLast)
               state_next = NTSR_DONE;
            else
               cnt_next = cnt_reg + 8'h01;
         NTSR_DONE:
            state_next = NTSR_IDLE;
         default:
            state_next = NTSR_IDLE;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         state_reg <= NTSR_IDLE;
         cnt_reg   <= 8'h00;
      end
      else if (clkEn)
      begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
      end
   end

   assign busy = (state_reg == NTSR_RESET);
   assign done = (state_reg == NTSR_DONE);
endmodule
`default_nettype wire

// ---- ntsr_top.sv ----
// module: nand tree test mode and phy soft reset register logic
//
// Added by the designer: the address map and strobed register access.
`default_nettype none
module ntsr_top
   import ntsr_pkg::*;
(
   input  wire logic                         clk,
   input  wire logic                         rst_n,
   input  wire logic                         clkEn,
   input  wire logic [ntsr_pkg::MODE_W-1:0]  modeStrap,
   input  wire logic                         refclkOutEnableStrap,
   input  wire logic                         statusLightB,
   input  wire logic                         statusLightAWakeOut,
   input  wire logic [3:0]                   txd,
   input  wire logic                         txc,
   input  wire logic                         txCtl,
   input  wire logic [3:0]                   rxd,
   input  wire logic                         rxCtl,
   input  wire logic                         rxc,
   input  wire logic                         interruptWakeOut,
   input  wire logic                         mdc,
   input  wire logic                         mdio,
   input  wire logic [ntsr_pkg::ADDR_W-1:0]  regAddr,
   input  wire logic [ntsr_pkg::DATA_W-1:0]  regWdata,
   input  wire logic                         regWr,
   input  wire logic                         regRd,
   output logic      [ntsr_pkg::DATA_W-1:0]  regRdata,
   output logic                              refclkOutTreeResult,
   output logic                              refclkOutTreeOe,
   output logic                              treeMode,
   output logic                              phyLogicReset
);
   import ntsr_pkg::*;

   // strap capture happens only in the first enabled cycle after reset release
   logic                   strapTaken_reg;
   logic [MODE_W-1:0]      strap_reg;
   logic                   clkoeStrap_reg;
   logic [DATA_W-1:0]      basicCtrl_reg;
   logic [DATA_W-1:0]      ctrl_reg;
   logic [DATA_W-1:0]      ioTune_reg;
   logic [DATA_W-1:0]      rxDll_reg;
   logic [DATA_W-1:0]      txDll_reg;
   logic [DATA_W-1:0]      trim_reg;
   logic [DATA_W-1:0]      ovrLo_reg;
   logic [DATA_W-1:0]      ovrHi_reg;
   logic [DATA_W-1:0]      dbgCtrl2_reg;
   logic [DATA_W-1:0]      ana_reg [ANA_NUM];
   logic [DATA_W-1:0]      rdata_next;
   logic [CHAIN_LEN-1:0]   chainIn;
   logic                   treeBit;
   logic                   seqBusy;
   logic                   seqDone;

   function automatic logic hit(input logic [ADDR_W-1:0] a,
                                input logic [ADDR_W-1:0] b);
      hit = (a == b);
   endfunction

   // register write decode
   wire wrBasic  = regWr && hit(regAddr, ADDR_BASIC_CTRL);
   wire wrCtrl   = regWr && hit(regAddr, ADDR_CTRL);
   wire wrIoTune = regWr && hit(regAddr, ADDR_IO_TUNE);
   wire wrRxDll  = regWr && hit(regAddr, ADDR_RX_DLL);
   wire wrTxDll  = regWr && hit(regAddr, ADDR_TX_DLL);
   wire wrTrim   = regWr && hit(regAddr, ADDR_TRIM);
   wire wrOvrLo  = regWr && hit(regAddr, ADDR_OVR_LO);
   wire wrOvrHi  = regWr && hit(regAddr, ADDR_OVR_HI);
   wire wrDbg2   = regWr && hit(regAddr, ADDR_DBG_CTRL2);
   wire [ADDR_W-1:0] anaIdx = regAddr - ADDR_ANA_BASE;
   wire anaSel = (regAddr >= ADDR_ANA_BASE) &&
                 (anaIdx < ADDR_W'(ANA_NUM));

   wire softStart = wrBasic && regWdata[BIT_SOFT_RST];
   wire softRst   = seqDone;
   wire afeRst    = wrDbg2 && regWdata[BIT_AFE_RST];
   // the low override register steers the effective mode when nonzero
   wire [MODE_W-1:0] effMode = (ovrLo_reg != RST_OVR) ?
                               ovrLo_reg[MODE_W-1:0] : strap_reg;

   assign chainIn = {mdio, mdc, interruptWakeOut, rxc, rxCtl,
                     rxd[0], rxd[1], rxd[2], rxd[3], txCtl, txc,
                     txd[3], txd[2], txd[1], txd[0],
                     statusLightAWakeOut, statusLightB};

   ntsr_nand_chain u_chain
   (
      .clk     (clk),
      .rst_n   (rst_n),
      .clkEn   (clkEn),
      .chainIn (chainIn),
      .treeOut (treeBit)
   );

   ntsr_reset_seq u_seq
   (
      .clk   (clk),
      .rst_n (rst_n),
      .clkEn (clkEn),
      .start (softStart),
      .busy  (seqBusy),
      .done  (seqDone)
   );

   // straps captured once; soft reset never reloads them
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         strapTaken_reg <= 1'b0;
         strap_reg      <= '0;
         clkoeStrap_reg <= 1'b0;
      end
      else if (clkEn && !strapTaken_reg)
      begin
         strapTaken_reg <= 1'b1;
         strap_reg      <= modeStrap;
         clkoeStrap_reg <= refclkOutEnableStrap;
      end
   end

   // soft-reset defaults; trims and overrides not touched
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         basicCtrl_reg <= RST_BASIC_CTRL;
         ctrl_reg      <= RST_CTRL;
         ioTune_reg    <= RST_IO_TUNE;
         rxDll_reg     <= RST_RX_DLL;
         txDll_reg     <= RST_TX_DLL;
         dbgCtrl2_reg  <= '0;
      end
      else if (clkEn)
      begin
         if (softRst)
         begin
            basicCtrl_reg <= RST_BASIC_CTRL;
            ctrl_reg      <= RST_CTRL;
            ioTune_reg    <= RST_IO_TUNE;
            rxDll_reg     <= RST_RX_DLL;
            txDll_reg     <= RST_TX_DLL;
            dbgCtrl2_reg  <= '0;
         end
         else
         begin
            if (wrBasic)
               basicCtrl_reg <= regWdata;
            // logic reset self clears: a one-cycle pulse
            if (wrCtrl)
               ctrl_reg <= regWdata;
            else
               ctrl_reg[BIT_LOGIC_RST] <= 1'b0;
            if (wrIoTune)
               ioTune_reg <= regWdata;
            if (wrRxDll)
               rxDll_reg <= regWdata;
            if (wrTxDll)
               txDll_reg <= regWdata;
            if (wrDbg2)
               dbgCtrl2_reg <= regWdata & ~(16'h0001 << BIT_AFE_RST);
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         trim_reg  <= RST_TRIM;
         ovrLo_reg <= RST_OVR;
         ovrHi_reg <= RST_OVR;
      end
      else if (clkEn)
      begin
         if (wrTrim)
            trim_reg <= regWdata;
         if (wrOvrLo)
            ovrLo_reg <= regWdata;
         if (wrOvrHi)
            ovrHi_reg <= regWdata;
      end
   end

   // analog registers: only hard reset or analog reset bit
   always_ff @(posedge clk)
   begin
      for (int k = 0; k < ANA_NUM; k++)
      begin
         if (!rst_n)
            ana_reg[k] <= RST_ANA;
         else if (clkEn)
         begin
            if (afeRst)
               ana_reg[k] <= RST_ANA;
            else if (regWr && anaSel && anaIdx == ADDR_W'(k))
               ana_reg[k] <= regWdata;
         end
      end
   end

   always_comb
   begin
      rdata_next = '0;
      if (anaSel)
         rdata_next = ana_reg[anaIdx[2:0]];
      else
         unique case (regAddr)
            ADDR_BASIC_CTRL: rdata_next = basicCtrl_reg;
            ADDR_CTRL:       rdata_next = ctrl_reg;
            ADDR_IO_TUNE:    rdata_next = ioTune_reg;
            ADDR_RX_DLL:     rdata_next = rxDll_reg;
            ADDR_TX_DLL:     rdata_next = txDll_reg;
            ADDR_TRIM:       rdata_next = trim_reg;
            ADDR_OVR_LO:     rdata_next = ovrLo_reg;
            ADDR_OVR_HI:     rdata_next = ovrHi_reg;
            ADDR_STRAP_CFG:  rdata_next = {10'h000, clkoeStrap_reg, effMode};
            ADDR_DBG_CTRL2:  rdata_next = dbgCtrl2_reg;
            ADDR_STATUS:     rdata_next = {13'h0000, seqBusy,
                                           treeMode, strapTaken_reg};
            default:         rdata_next = '0;
         endcase
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         regRdata            <= '0;
         treeMode            <= 1'b0;
         refclkOutTreeResult <= 1'b0;
         refclkOutTreeOe     <= 1'b0;
         phyLogicReset       <= 1'b0;
      end
      else if (clkEn)
      begin
         regRdata <= regRd ? rdata_next : '0;
         treeMode <= strapTaken_reg && (strap_reg == MODE_NAND_TREE);
         refclkOutTreeResult <= treeMode ? treeBit : 1'b0;
         refclkOutTreeOe     <= clkoeStrap_reg;
         // logic reset leaves registers alone, pulses the core reset
         phyLogicReset <= ctrl_reg[BIT_LOGIC_RST] || seqBusy;
      end
   end

   // helper: enabled edges since an accepted soft reset strobe
   logic [3:0] softAge;
   wire  [3:0] softAgeEnd = 4'(RST_CYCLES) + 4'h2;

   always_ff @(posedge clk)
   begin
      if (!rst_n)
         softAge <= 4'h0;
      else if (clkEn)
      begin
         if (softStart && !seqBusy && !seqDone)
            softAge <= 4'h1;
         else if (softAge != 4'h0 && softAge != softAgeEnd)
            softAge <= softAge + 4'h1;
      end
   end

   sequence s_softWrite;
      clkEn && softStart && !seqBusy && !seqDone;
   endsequence

   a_soft_busy : assert property (
      @(posedge clk) disable iff (!rst_n)
      s_softWrite |=> seqBusy)
      else $error("soft reset sequence did not start");
   a_soft_selfclear : assert property (
      @(posedge clk) disable iff (!rst_n)
      softAge == softAgeEnd |-> !basicCtrl_reg[BIT_SOFT_RST])
      else $error("soft reset bit did not clear");
   a_trim_kept : assert property (
      @(posedge clk) disable iff (!rst_n)
      clkEn && softRst && !wrTrim |=> $stable(trim_reg))
      else $error("trim changed by soft reset");
   a_dll_reset : assert property (
      @(posedge clk) disable iff (!rst_n)
      clkEn && softRst |=> rxDll_reg == RST_RX_DLL &&
      txDll_reg == RST_TX_DLL && ioTune_reg == RST_IO_TUNE)
      else $error("tuning registers not reset");
   a_ctrl_reset : assert property (
      @(posedge clk) disable iff (!rst_n)
      clkEn && softRst |=> basicCtrl_reg == RST_BASIC_CTRL &&
      ctrl_reg == RST_CTRL)
      else $error("control registers not reset");
   a_ovr_kept : assert property (
      @(posedge clk) disable iff (!rst_n)
      clkEn && softRst && !wrOvrLo |=>
      $stable(ovrLo_reg) && $stable(strap_reg))
      else $error("overrides or straps disturbed");
   a_ana_kept : assert property (
      @(posedge clk) disable iff (!rst_n)
      clkEn && softRst && !regWr |=> $stable(ana_reg[0]))
      else $error("analog register changed by soft reset");
   a_logic_regs : assert property (
      @(posedge clk) disable iff (!rst_n)
      clkEn && wrCtrl && regWdata[BIT_LOGIC_RST] ##1 clkEn && !regWr
      |=> phyLogicReset && $stable(trim_reg))
      else $error("logic reset misbehaved");
   a_tree_mode : assert property (
      @(posedge clk) disable iff (!rst_n)
      clkEn && strapTaken_reg && strap_reg != MODE_NAND_TREE |=> !treeMode)
      else $error("tree mode without strap code");
   a_tree_out : assert property (
      @(posedge clk) disable iff (!rst_n)
      clkEn && !treeMode |=> !clkEn || !refclkOutTreeResult)
      else $error("tree result outside tree mode");
endmodule
`default_nettype wire

// ---- ntsr_board_tester.sv ----
// board tester model: sets mode straps and biases the tree pins
`default_nettype none
module ntsr_board_tester
   import ntsr_pkg::*;
(
   input  wire logic                           useBias,
   input  wire logic [4:0]                     testPos,
   input  wire logic                           testLevel,
   input  wire logic [ntsr_pkg::CHAIN_LEN-1:0] freeVec,
   input  wire logic                           treeWanted,
   input  wire logic [ntsr_pkg::MODE_W-1:0]    otherMode,
   output logic      [ntsr_pkg::CHAIN_LEN-1:0] pins,
   output logic      [ntsr_pkg::MODE_W-1:0]    modeStrap,
   output logic                                oeStrap
);
   timeunit 1ns;
   timeprecision 1ps;
   // tree code only when the board asks for test mode
   assign modeStrap = treeWanted ? MODE_NAND_TREE : otherMode;
   // refclk pin must be an output or the tree result is invisible
   assign oeStrap = treeWanted;
   always_comb
   begin
      pins = freeVec;
      if (useBias && testPos != 5'h00)
      begin
         for (int i = 0; i < CHAIN_LEN; i++)
            pins[i] = (i + 1 < int'(testPos)) ? 1'b0 : 1'b1;
         pins[testPos - 5'h01] = testLevel;
      end
   end
endmodule
`default_nettype wire

// ---- ntsr_top_tb.sv ----
// self-checking bench for the nand tree and soft reset block
`default_nettype none
module ntsr_top_tb
   import ntsr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic                 clk, rst_n, regWr, regRd, useBias, testLevel;
   logic                 treeWanted, oeStrap, treeOut, treeOe;
   logic                 treeMode, logicRst, seen, clkEn;
   logic [4:0]           regAddr, testPos, otherMode, modeStrap;
   logic [15:0]          regWdata, regRdata;
   logic [CHAIN_LEN-1:0] freeVec, pins;
   logic [15:0]          mdl [0:31];
   logic [4:0]           regList [$];
   int                   n_fail, checked;

   ntsr_board_tester tester (.useBias(useBias), .testPos(testPos),
      .testLevel(testLevel), .freeVec(freeVec), .treeWanted(treeWanted),
      .otherMode(otherMode), .pins(pins), .modeStrap(modeStrap),
      .oeStrap(oeStrap));

   ntsr_top dut (.clk(clk), .rst_n(rst_n), .clkEn(clkEn),
      .modeStrap(modeStrap), .refclkOutEnableStrap(oeStrap),
      .statusLightB(pins[0]), .statusLightAWakeOut(pins[1]),
      .txd(pins[5:2]), .txc(pins[6]), .txCtl(pins[7]),
      .rxd({pins[8], pins[9], pins[10], pins[11]}), .rxCtl(pins[12]),
      .rxc(pins[13]), .interruptWakeOut(pins[14]), .mdc(pins[15]),
      .mdio(pins[16]), .regAddr(regAddr), .regWdata(regWdata),
      .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
      .refclkOutTreeResult(treeOut), .refclkOutTreeOe(treeOe),
      .treeMode(treeMode), .phyLogicReset(logicRst));

   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   function automatic logic tree_of(input logic [CHAIN_LEN-1:0] v);
      logic s;
      s = 1'b1;
      for (int i = 0; i < CHAIN_LEN; i++)
         s = ~(v[i] & s);
      return ~s;
   endfunction

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic check(input string what, input logic [15:0] got,
                        input logic [15:0] exp);
      checked++;
      if (got !== exp)
      begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic reg_wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge clk);
      regWr    <= 1'b1;
      regAddr  <= a;
      regWdata <= d;
      @(posedge clk);
      regWr <= 1'b0;
   endtask

   task automatic reg_rd(input logic [4:0] a, output logic [15:0] d);
      @(posedge clk);
      regRd   <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRd <= 1'b0;
      #1;
      d = regRdata;
   endtask

   task automatic check_regs();
      logic [15:0] d;
      foreach (regList[i])
      begin
         reg_rd(regList[i], d);
         check($sformatf("reg %h", regList[i]), d, mdl[regList[i]]);
      end
   endtask

   task automatic do_reset(input logic tree, input logic [4:0] m);
      @(posedge clk);
      rst_n      <= 1'b0;
      treeWanted <= tree;
      otherMode  <= m;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      #1;
      foreach (mdl[i])
         mdl[i] = 16'h0000;
      mdl[ADDR_BASIC_CTRL] = RST_BASIC_CTRL;
      check("treeMode", 16'(treeMode), 16'(modeStrap == 5'b00100));
      check("tree oe", 16'(treeOe), 16'(oeStrap));
   endtask

   // a zero position leaves the pins random
   task automatic tree_step(input logic [4:0] p, input logic l);
      logic e;
      @(posedge clk);
      useBias   <= (p != 5'h00);
      testPos   <= p;
      testLevel <= l;
      freeVec   <= CHAIN_LEN'($urandom);
      repeat (3) @(posedge clk);
      #1;
      e = treeWanted & tree_of(pins);
      check("tree out", 16'(treeOut), 16'(e));
      if (p != 5'h00)
         check("parity", 16'(treeOut), 16'(treeWanted & (l ^ !p[0])));
   endtask

   initial
   begin
      repeat (60000) @(posedge clk);
      n_fail++;
      $display("MISMATCH run expected finish seen timeout");
      give_verdict();
   end

   initial
   begin
      logic [15:0] d;
      int          m;
      logic [4:0]  modes [5];
      rst_n = 1'b0; regWr = 1'b0; regRd = 1'b0; regAddr = 5'h00;
      regWdata = 16'h0000; useBias = 1'b0; testPos = 5'h00;
      testLevel = 1'b0; freeVec = '0; treeWanted = 1'b1; otherMode = 5'h00;
      clkEn = 1'b1;
      void'($urandom(6419));
      regList = '{ADDR_BASIC_CTRL, ADDR_IO_TUNE, ADDR_RX_DLL, ADDR_TX_DLL,
                  ADDR_TRIM, ADDR_OVR_LO, ADDR_OVR_HI};
      for (int i = 0; i < ANA_NUM; i++)
         regList.push_back(ADDR_ANA_BASE + 5'(i));
      do_reset(1'b1, 5'h00);
      for (int p = 1; p <= CHAIN_LEN; p++)
         for (int l = 0; l < 2; l++)
            tree_step(5'(p), 1'(l));
      repeat (30) tree_step(5'h00, 1'b0);
      // neighbours of the tree code must not select it
      modes = '{5'h00, 5'h05, 5'h0C, 5'h14, 5'h1F};
      foreach (modes[k])
      begin
         do_reset(1'b0, modes[k]);
         repeat (3) tree_step(5'h00, 1'b0);
      end
      reg_rd(5'h1F, d);
      check("unmapped", d, 16'h0000);
      check_regs();
      foreach (regList[i])
      begin
         if (regList[i] == ADDR_BASIC_CTRL)
            continue;
         d = 16'($urandom);
         // a nonzero mode override steers the strap readback
         if (regList[i] == ADDR_OVR_LO)
            d[0] = 1'b1;
         reg_wr(regList[i], d);
         mdl[regList[i]] = d;
      end
      check_regs();
      reg_wr(ADDR_BASIC_CTRL, 16'h8000);
      @(posedge clk);
      #1;
      check("logic rst in soft", 16'(logicRst), 16'h0001);
      m = 0;
      d = 16'hFFFF;
      while (d[BIT_SOFT_RST] !== 1'b0 && m < 20)
      begin
         reg_rd(ADDR_BASIC_CTRL, d);
         m++;
      end
      check("soft bit", 16'(d[BIT_SOFT_RST]), 16'h0000);
      // trim, overrides and analog registers survive
      mdl[ADDR_BASIC_CTRL] = RST_BASIC_CTRL;
      mdl[ADDR_IO_TUNE]    = RST_IO_TUNE;
      mdl[ADDR_RX_DLL]     = RST_RX_DLL;
      mdl[ADDR_TX_DLL]     = RST_TX_DLL;
      check_regs();
      reg_rd(ADDR_STRAP_CFG, d);
      check("strap", d, 16'({oeStrap, mdl[ADDR_OVR_LO][4:0]}));
      reg_wr(ADDR_CTRL, 16'h0001);
      seen = 1'b0;
      repeat (4)
      begin
         @(posedge clk);
         #1;
         seen = seen | (logicRst === 1'b1);
      end
      check("logic reset", 16'(seen), 16'h0001);
      check("logic reset end", 16'(logicRst), 16'h0000);
      check_regs();
      // a write while the clock enable is low must be lost
      @(posedge clk);
      clkEn <= 1'b0;
      reg_wr(ADDR_TRIM, 16'hA5A5);
      @(posedge clk);
      clkEn <= 1'b1;
      check_regs();
      reg_wr(ADDR_DBG_CTRL2, 16'h0001);
      for (int i = 0; i < ANA_NUM; i++)
         mdl[ADDR_ANA_BASE + 5'(i)] = RST_ANA;
      check_regs();
      give_verdict();
   end
endmodule
`default_nettype wire
